// >>> misw_core_model.sv
// Purpose: Processor core stand-in that accepts interrupt vectors
// Assumes: Take only while the request is high; delay_i sets how slowly it answers
// Notes:   Plain return instead of reti while reti_en_i is low
`timescale 1ns/1ps
`default_nettype none
module misw_core_model (
  input  wire logic            mclk_i,
  input  wire logic            rst_n_i,
  input  wire logic            irq_req_i,
  input  wire logic [3:0]      delay_i,
  input  wire logic            reti_en_i,
  input  wire logic            stack_full_i,
  output var misw_pkg::misw_core_t core_o
);
  logic [3:0] wait_r;
  logic       busy_r;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_r <= 4'h0;
      busy_r <= 1'b0;
      core_o <= '0;
    end else begin
      core_o.take <= 1'b0;
      core_o.reti <= 1'b0;
      core_o.stack_full <= stack_full_i;
      if (!busy_r && irq_req_i && !core_o.take) begin
        wait_r <= (wait_r >= delay_i) ? 4'h0 : wait_r + 4'h1;
        busy_r <= (wait_r >= delay_i);
        core_o.take <= (wait_r >= delay_i);
      end else if (busy_r) begin
        // Short service routine, then return
        wait_r <= (wait_r == 4'h6) ? 4'h0 : wait_r + 4'h1;
        busy_r <= (wait_r != 4'h6);
        core_o.reti <= (wait_r == 4'h6) && reti_en_i;
      end
    end
  end
endmodule : misw_core_model
`default_nettype wire

// >>> misw_irq.sv
// Purpose: Interrupt flags, enables, vectoring and wake-up for a small controller
// Assumes: event inputs are same-clock pulses or levels; core takes vectors on take
// Notes:   Priority: conversion, low voltage, eeprom, group 0, 1, 2
// Contract
// - Time-base bit 7 enable, bits 2..0 period
// - Time-base bits 6..3 read zero
// - Conversion finish sets conversion flag
// - Independent vector needs flag, enables, stack room
// - Conversion service clears flag and global enable
// - Low-voltage report sets low-voltage flag
// - Low-voltage service clears flag and global enable
// - EEPROM write end sets its flag
// - EEPROM service clears flag and global enable
// - Three groups aggregate touch and timer requests
// - Member flag rising sets group flag
// - Group vector needs global, member, group enables
// - Group service clears group flag and global enable, not member flags
// - Touch slot overflow sets its flag
// - Touch count compared against selected threshold
// - Each timer has A and P flags
// - Any rising flag wakes the device
// - Flags stay set until serviced or cleared
// - Requests recorded while global enable off
// - Return-from-interrupt sets global enable again
`timescale 1ns/1ps
`default_nettype none
module misw_irq #(
  parameter int unsigned TB_CW = 16
) (
  input  wire logic                  mclk_i,
  input  wire logic                  rst_n_i,
  input  wire logic [3:0]            addr_i,
  input  wire logic [7:0]            wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic      [7:0]            rdata_o,
  input  wire misw_pkg::misw_events_t ev_i,
  input  wire misw_pkg::misw_core_t  core_i,
  input  wire logic                  prescaler1_clock_i,
  output logic                       irq_req_o,
  output logic      [2:0]            irq_vec_o,
  output logic                       wake_o,
  output logic                       tb1_ovf_o
);
  localparam int unsigned NV = misw_pkg::NUM_VEC;
  localparam int unsigned NM = misw_pkg::NUM_MB;

  logic [7:0]    time_base1_control_r;
  logic          global_irq_enable_r;
  logic          threshold_direction_select_r;
  logic [NV-1:0] flag_r;
  logic [NV-1:0] flag_nxt;
  logic [NV-1:0] enab_r;
  logic [NM-1:0] mflag_r;
  logic [NM-1:0] mflag_nxt;
  logic [NM-1:0] menab_r;
  logic [15:0]   th_lo_r;
  logic [15:0]   th_up_r;
  logic          tb_ovf_w;
  logic          tb1_flag_r;

  // Register decode
  wire w_time_base1_control  = wr_i && (addr_i == misw_pkg::OFF_TIME_BASE1_CONTROL);
  wire w_ctrl  = wr_i && (addr_i == misw_pkg::OFF_CTRL);
  wire w_flags = wr_i && (addr_i == misw_pkg::OFF_FLAGS);
  wire w_enab  = wr_i && (addr_i == misw_pkg::OFF_ENAB);
  wire w_mflg  = wr_i && (addr_i == misw_pkg::OFF_MFLG);
  wire w_mena  = wr_i && (addr_i == misw_pkg::OFF_MENA);
  wire w_thlo  = wr_i && (addr_i == misw_pkg::OFF_THLO);
  wire w_thhi  = wr_i && (addr_i == misw_pkg::OFF_THHI);
  wire w_tulo  = wr_i && (addr_i == misw_pkg::OFF_TULO);
  wire w_tuhi  = wr_i && (addr_i == misw_pkg::OFF_TUHI);

  // Second time base
  wire       tb_en_w  = time_base1_control_r[misw_pkg::TB_EN_BIT];
  wire [2:0] tb_sel_w = time_base1_control_r[2:0];
  misw_timebase #(.CW(TB_CW)) u_tb (
    .mclk_i   (mclk_i),
    .rst_n_i  (rst_n_i),
    .enable_i (tb_en_w),
    .tick_i   (prescaler1_clock_i),
    .period_i (tb_sel_w),
    .ovf_o    (tb_ovf_w)
  );

  // Member events
  wire touch_threshold_event = ev_i.touch_valid &&
    (threshold_direction_select_r ? (ev_i.touch_count > th_up_r)
                                  : (ev_i.touch_count < th_lo_r));
  wire [NM-1:0] mset_w = {ev_i.tm_match[3], ev_i.tm_match[2], ev_i.tm_match[1],
                          ev_i.tm_match[0], touch_threshold_event,
                          ev_i.touch_slot_ovf};
  wire [NM-1:0] mrise_w = mset_w & ~mflag_r;

  // Group aggregation: a member flag going high sets its group flag
  wire [2:0] grp_set_w = {|mrise_w[5:4], |mrise_w[3:2], |mrise_w[1:0]};

  wire [NV-1:0] set_w = {grp_set_w, ev_i.eeprom_done, ev_i.low_voltage,
                         ev_i.adc_done};

  // Group qualification needs a member both flagged and enabled
  wire [2:0] mqual_w = {|(mflag_r[5:4] & menab_r[5:4]), |(mflag_r[3:2] & menab_r[3:2]),
                        |(mflag_r[1:0] & menab_r[1:0])};
  wire [NV-1:0] qual_w = {mqual_w, 3'b111};
  wire [NV-1:0] pend_w = flag_r & enab_r & qual_w;
  wire          can_w  = global_irq_enable_r && !core_i.stack_full;

  function automatic logic [2:0] pick(input logic [NV-1:0] p);
    logic [2:0] v;
    v = misw_pkg::VEC_NONE;
    for (int i = NV - 1; i >= 0; i--) begin
      if (p[i]) begin
        v = 3'(i);
      end
    end
    return v;
  endfunction : pick

  wire [2:0]    vec_w  = pick(pend_w);
  wire          req_w  = can_w && (|pend_w);
  wire          serv_w = core_i.take && irq_req_o;
  wire [NV-1:0] svc_w  = serv_w ? NV'(1 << irq_vec_o) : '0;

  // Set beats clear; flags held until service or software clear
  assign flag_nxt  = ((w_flags ? wdata_i[NV-1:0] : flag_r) & ~svc_w) | set_w;
  assign mflag_nxt = (w_mflg ? wdata_i[NM-1:0] : mflag_r) | mset_w;

  // Wake on any flag rising, enables ignored
  wire wake_w = (|(set_w & ~flag_r)) || (|mrise_w) || (tb_ovf_w && !tb1_flag_r);

  wire gie_nxt = core_i.reti ? 1'b1 : (serv_w ? 1'b0 :
                 (w_ctrl ? wdata_i[misw_pkg::CTL_GIE_BIT] : global_irq_enable_r));

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      time_base1_control_r                       <= misw_pkg::TIME_BASE1_CONTROL_RST;
      global_irq_enable_r          <= 1'b0;
      threshold_direction_select_r <= 1'b0;
      flag_r                       <= '0;
      enab_r                       <= '0;
      mflag_r                      <= '0;
      menab_r                      <= '0;
      th_lo_r                      <= 16'h0000;
      th_up_r                      <= 16'hFFFF;
      tb1_flag_r                   <= 1'b0;
    end else begin
      if (w_time_base1_control) begin
        time_base1_control_r <= {wdata_i[7], 4'h0, wdata_i[2:0]};
      end
      if (w_ctrl) begin
        threshold_direction_select_r <= wdata_i[misw_pkg::CTL_THS_BIT];
      end
      global_irq_enable_r <= gie_nxt;
      flag_r              <= flag_nxt;
      mflag_r             <= mflag_nxt;
      if (w_enab) begin
        enab_r <= wdata_i[NV-1:0];
      end
      if (w_mena) begin
        menab_r <= wdata_i[NM-1:0];
      end
      if (w_thlo) begin
        th_lo_r[7:0] <= wdata_i;
      end
      if (w_thhi) begin
        th_lo_r[15:8] <= wdata_i;
      end
      if (w_tulo) begin
        th_up_r[7:0] <= wdata_i;
      end
      if (w_tuhi) begin
        th_up_r[15:8] <= wdata_i;
      end
      if (tb_ovf_w) begin
        tb1_flag_r <= 1'b1;
      end else if (w_ctrl && wdata_i[misw_pkg::CTL_TBF_BIT]) begin
        tb1_flag_r <= 1'b0;
      end
    end
  end

  // Read mux
  logic [7:0] rd_w;
  always_comb begin
    case (addr_i)
      misw_pkg::OFF_TIME_BASE1_CONTROL:  rd_w = time_base1_control_r;
      misw_pkg::OFF_CTRL:  rd_w = {5'h00, tb1_flag_r, threshold_direction_select_r, global_irq_enable_r};
      misw_pkg::OFF_FLAGS: rd_w = {2'b00, flag_r};
      misw_pkg::OFF_ENAB:  rd_w = {2'b00, enab_r};
      misw_pkg::OFF_MFLG:  rd_w = {2'b00, mflag_r};
      misw_pkg::OFF_MENA:  rd_w = {2'b00, menab_r};
      misw_pkg::OFF_THLO:  rd_w = th_lo_r[7:0];
      misw_pkg::OFF_THHI:  rd_w = th_lo_r[15:8];
      misw_pkg::OFF_TULO:  rd_w = th_up_r[7:0];
      misw_pkg::OFF_TUHI:  rd_w = th_up_r[15:8];
      misw_pkg::OFF_VECT:  rd_w = {4'h0, irq_req_o, irq_vec_o};
      default:             rd_w = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o     <= 8'h00;
      irq_req_o   <= 1'b0;
      irq_vec_o   <= misw_pkg::VEC_NONE;
      wake_o      <= 1'b0;
      tb1_ovf_o   <= 1'b0;
    end else begin
      rdata_o     <= rd_i ? rd_w : 8'h00;
      // Drop request right after a take so one vector per service
      irq_req_o   <= req_w && !serv_w && !core_i.reti;
      irq_vec_o   <= vec_w;
      wake_o      <= wake_w;
      tb1_ovf_o   <= tb_ovf_w;
    end
  end

  // Checks
  svc_clears_gie_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    serv_w && !core_i.reti |=> !global_irq_enable_r)
    else $error("service left global enable");

  reti_sets_gie_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    core_i.reti |=> global_irq_enable_r)
    else $error("return did not enable");

  adc_sets_flag_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ev_i.adc_done |=> flag_r[misw_pkg::IDX_ADC])
    else $error("conversion flag not set");

  lvd_sets_flag_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ev_i.low_voltage |=> flag_r[misw_pkg::IDX_LVD])
    else $error("low voltage flag not set");

  eep_sets_flag_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ev_i.eeprom_done |=> flag_r[misw_pkg::IDX_EEP])
    else $error("eeprom flag not set");

  req_needs_gie_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    irq_req_o |-> $past(global_irq_enable_r) && !$past(core_i.stack_full))
    else $error("request without gate");

  member_kept_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    serv_w && !w_mflg |=> mflag_r == ($past(mflag_r) | $past(mset_w)))
    else $error("member flag lost");

  wake_on_rise_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ev_i.adc_done && !flag_r[misw_pkg::IDX_ADC] |=> wake_o)
    else $error("no wake on rise");

  tb_zero_bits_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    time_base1_control_r[6:3] == 4'h0)
    else $error("time base reserved bits set");

  flag_held_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    flag_r[0] && !svc_w[0] && !w_flags |=> flag_r[0])
    else $error("flag dropped");

  adc_svc_clr_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    serv_w && irq_vec_o == 3'(misw_pkg::IDX_ADC) && !ev_i.adc_done |=> !flag_r[misw_pkg::IDX_ADC])
    else $error("conversion flag kept after service");

  lvd_svc_clr_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    serv_w && irq_vec_o == 3'(misw_pkg::IDX_LVD) && !ev_i.low_voltage |=> !flag_r[misw_pkg::IDX_LVD])
    else $error("low voltage flag kept after service");

  eep_svc_clr_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    serv_w && irq_vec_o == 3'(misw_pkg::IDX_EEP) && !ev_i.eeprom_done |=> !flag_r[misw_pkg::IDX_EEP])
    else $error("eeprom flag kept after service");

  grp0_svc_clr_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    serv_w && irq_vec_o == 3'(misw_pkg::IDX_MF0) && !grp_set_w[0] |=> !flag_r[misw_pkg::IDX_MF0])
    else $error("group 0 flag kept after service");

  grp1_svc_clr_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    serv_w && irq_vec_o == 3'(misw_pkg::IDX_MF1) && !grp_set_w[1] |=> !flag_r[misw_pkg::IDX_MF1])
    else $error("group 1 flag kept after service");

  grp2_svc_clr_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    serv_w && irq_vec_o == 3'(misw_pkg::IDX_MF2) && !grp_set_w[2] |=> !flag_r[misw_pkg::IDX_MF2])
    else $error("group 2 flag kept after service");

  grp0_set_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    |mrise_w[1:0] |=> flag_r[misw_pkg::IDX_MF0])
    else $error("group 0 flag not set");

  grp1_set_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    |mrise_w[3:2] |=> flag_r[misw_pkg::IDX_MF1])
    else $error("group 1 flag not set");

  grp2_set_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    |mrise_w[5:4] |=> flag_r[misw_pkg::IDX_MF2])
    else $error("group 2 flag not set");

  tkov_member_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ev_i.touch_slot_ovf |=> mflag_r[misw_pkg::MB_TKOV])
    else $error("slot overflow flag not set");

  th_low_member_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ev_i.touch_valid && !threshold_direction_select_r && (ev_i.touch_count < th_lo_r)
    |=> mflag_r[misw_pkg::MB_TOUCH_THRESHOLD_EVENT])
    else $error("low threshold flag not set");

  th_up_member_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ev_i.touch_valid && threshold_direction_select_r && (ev_i.touch_count > th_up_r)
    |=> mflag_r[misw_pkg::MB_TOUCH_THRESHOLD_EVENT])
    else $error("upper threshold flag not set");

  t0a_member_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ev_i.tm_match[0] |=> mflag_r[misw_pkg::MB_T0A])
    else $error("timer 0 A flag not set");

  t0p_member_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ev_i.tm_match[1] |=> mflag_r[misw_pkg::MB_T0P])
    else $error("timer 0 P flag not set");

  t1a_member_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ev_i.tm_match[2] |=> mflag_r[misw_pkg::MB_T1A])
    else $error("timer 1 A flag not set");

  t1p_member_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ev_i.tm_match[3] |=> mflag_r[misw_pkg::MB_T1P])
    else $error("timer 1 P flag not set");

  one_vector_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    serv_w |=> !irq_req_o)
    else $error("request held after take");

  vec_priority_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    irq_req_o && irq_vec_o != 3'h0 |-> !$past(pend_w[0]))
    else $error("lower vector beat conversion");

  req_when_gated_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    can_w && (|pend_w) && !serv_w && !core_i.reti |=> irq_req_o)
    else $error("gated request not raised");

  no_take_off_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !global_irq_enable_r |=> !irq_req_o)
    else $error("request while global enable off");

  member_held_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    mflag_r[misw_pkg::MB_TKOV] && !w_mflg |=> mflag_r[misw_pkg::MB_TKOV])
    else $error("member flag dropped");

  tb_off_quiet_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !tb_en_w |=> !tb_ovf_w)
    else $error("time base ran while off");
endmodule : misw_irq
`default_nettype wire

// >>> misw_pkg.sv
// Purpose: Shared constants and types for the interrupt source and wake-up block
// Assumes: 8-bit register port, one system clock
// Notes:   Group membership: group 0 touch keys, group 1 timer 0, group 2 timer 1
package misw_pkg;
  localparam int unsigned REG_AW = 4;
  localparam logic [3:0] OFF_TIME_BASE1_CONTROL  = 4'h0;
  localparam logic [3:0] OFF_CTRL  = 4'h1;
  localparam logic [3:0] OFF_FLAGS = 4'h2;
  localparam logic [3:0] OFF_ENAB  = 4'h3;
  localparam logic [3:0] OFF_MFLG  = 4'h4;
  localparam logic [3:0] OFF_MENA  = 4'h5;
  localparam logic [3:0] OFF_THLO  = 4'h6;
  localparam logic [3:0] OFF_THHI  = 4'h7;
  localparam logic [3:0] OFF_TULO  = 4'h8;
  localparam logic [3:0] OFF_TUHI  = 4'h9;
  localparam logic [3:0] OFF_VECT  = 4'hA;
  // Time-base control fields
  localparam int unsigned TB_EN_BIT = 7;
  localparam int unsigned TB_BASE_EXP = 8;
  localparam logic [7:0] TIME_BASE1_CONTROL_RST = 8'h00;
  // Control register fields
  localparam int unsigned CTL_GIE_BIT = 0;
  localparam int unsigned CTL_THS_BIT = 1;
  localparam int unsigned CTL_TBF_BIT = 2;
  // Independent and group flag/enable bit positions
  localparam int unsigned IDX_ADC = 0;
  localparam int unsigned IDX_LVD = 1;
  localparam int unsigned IDX_EEP = 2;
  localparam int unsigned IDX_MF0 = 3;
  localparam int unsigned IDX_MF1 = 4;
  localparam int unsigned IDX_MF2 = 5;
  localparam int unsigned NUM_VEC = 6;
  // Member flag positions
  localparam int unsigned MB_TKOV = 0;
  localparam int unsigned MB_TOUCH_THRESHOLD_EVENT = 1;
  localparam int unsigned MB_T0A  = 2;
  localparam int unsigned MB_T0P  = 3;
  localparam int unsigned MB_T1A  = 4;
  localparam int unsigned MB_T1P  = 5;
  localparam int unsigned NUM_MB  = 6;
  localparam logic [2:0] VEC_NONE = 3'h7;

  typedef struct packed {
    logic       adc_done;
    logic       low_voltage;
    logic       eeprom_done;
    logic       touch_slot_ovf;
    logic       touch_valid;
    logic [15:0] touch_count;
    logic [3:0] tm_match;
  } misw_events_t;

  typedef struct packed {
    logic       take;
    logic       reti;
    logic       stack_full;
  } misw_core_t;
endpackage : misw_pkg

// >>> misw_tb.sv
// Purpose: Self-checking bench for the interrupt source and wake-up block
// Assumes: Reads and vectors are checked against queues by a monitor
// Notes:   Time base checked by the spacing of two timeout pulses
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                   mclk_i, rst_n_i, wr_i, rd_i, rd_d, tick, reti_en, stack_full;
  logic [3:0]             addr_i, delay;
  logic [7:0]             wdata_i, rdata_o, rq[$];
  logic [2:0]             irq_vec_o, vq[$];
  logic                   irq_req_o, wake_o, tb1_ovf_o;
  misw_pkg::misw_events_t ev;
  misw_pkg::misw_core_t   core;
  int                     n_mismatch = 0, n_compared = 0, cyc = 0, t0;

  misw_irq #(.TB_CW(16)) i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ev_i(ev), .core_i(core), .prescaler1_clock_i(tick),
    .irq_req_o(irq_req_o), .irq_vec_o(irq_vec_o), .wake_o(wake_o), .tb1_ovf_o(tb1_ovf_o));
  misw_core_model i_core (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .irq_req_i(irq_req_o), .delay_i(delay),
    .reti_en_i(reti_en), .stack_full_i(stack_full), .core_o(core));

  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    rq.push_back(exp);
    @(posedge mclk_i);
    rd_i <= 1'b0;
  endtask : rd

  // One-cycle event, then wake-up seen in the same cycle as the flag edge
  task automatic pulse(input logic [24:0] e, input logic wk);
    @(posedge mclk_i);
    ev <= misw_pkg::misw_events_t'(e);
    delay <= 4'($urandom % 8);
    @(posedge mclk_i);
    ev <= '0;
    @(negedge mclk_i);
    check({15'h0, wake_o}, {15'h0, wk});
  endtask : pulse

  task automatic settle();
    for (int k = 0; k < 300 && vq.size() > 0; k++) @(posedge mclk_i);
    repeat (12) @(posedge mclk_i);
    check(16'(vq.size()), 16'h0);
  endtask : settle

  task automatic wait_ovf();
    int k;
    for (k = 0; k < 5000 && tb1_ovf_o !== 1'b1; k++) @(negedge mclk_i);
    check(16'(k / 5000), 16'h0);
  endtask : wait_ovf

  always @(posedge mclk_i) begin
    rd_d <= rd_i;
    cyc <= cyc + 1;
  end

  always @(negedge mclk_i) begin
    if (rd_d === 1'b1 && rq.size() > 0) check({8'h0, rdata_o}, {8'h0, rq.pop_front()});
    if (core.take === 1'b1) check({13'h0, irq_vec_o}, vq.size() ? {13'h0, vq.pop_front()} : 16'hEE);
  end

  initial begin
    #400_000;
    n_mismatch++;
    give_verdict();
  end

  initial begin
    logic [7:0] v;
    void'($urandom(32'h6e30ec7a));
    {rst_n_i, wr_i, rd_i, addr_i, wdata_i, ev, delay, stack_full} = '0;
    reti_en = 1'b1;
    tick = 1'b1;
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 16; i++) if (i != 10) rd(4'(i), (i == 8 || i == 9) ? 8'hFF : 8'h00);
    repeat (4) begin
      v = 8'($urandom);
      wr(4'h0, v);
      rd(4'h0, v & 8'h87);
    end
    wr(4'hC, 8'hFF);
    rd(4'hC, 8'h00);
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h04);
    for (int i = 0; i < 3; i++) pulse(25'h1 << (24 - i), 1'b1);
    pulse(25'h1 << 24, 1'b0);
    rd(4'h2, 8'h07);
    stack_full <= 1'b1;
    wr(4'h3, 8'h07);
    wr(4'h1, 8'h01);
    repeat (8) @(negedge mclk_i);
    check({15'h0, irq_req_o}, 16'h0);
    vq = '{3'd0, 3'd1, 3'd2};
    @(posedge mclk_i);
    stack_full <= 1'b0;
    settle();
    rd(4'h2, 8'h00);
    rd(4'h1, 8'h01);
    reti_en <= 1'b0;
    vq.push_back(3'd0);
    pulse(25'h1 << 24, 1'b1);
    settle();
    rd(4'h1, 8'h00);
    reti_en <= 1'b1;
    wr(4'h5, 8'h3E);
    wr(4'h3, 8'h38);
    wr(4'h6, 8'h00);
    wr(4'h7, 8'h01);
    wr(4'h1, 8'h01);
    pulse(25'h1 << 21, 1'b1);
    settle();
    vq.push_back(3'd3);
    wr(4'h5, 8'h3F);
    settle();
    pulse({5'b00001, 16'h0100, 4'h0}, 1'b0);
    vq.push_back(3'd3);
    pulse({5'b00001, 8'h00, 8'($urandom), 4'h0}, 1'b1);
    settle();
    for (int i = 0; i < 4; i++) begin
      vq.push_back(3'(4 + i / 2));
      pulse(25'h1 << i, 1'b1);
      settle();
    end
    rd(4'h4, 8'h3F);
    rd(4'h2, 8'h00);
    wr(4'h4, 8'h00);
    wr(4'h8, 8'h00);
    wr(4'h9, 8'h80);
    wr(4'h1, 8'h03);
    pulse({5'b00001, 16'h8000, 4'h0}, 1'b0);
    vq.push_back(3'd3);
    pulse({5'b00001, 1'b1, 15'($urandom) | 15'h1, 4'h0}, 1'b1);
    settle();
    rd(4'h4, 8'h02);
    for (int c = 0; c < 3; c++) begin
      wr(4'h0, 8'h80 | 8'(c));
      @(negedge mclk_i);
      wait_ovf();
      t0 = cyc;
      @(negedge mclk_i);
      wait_ovf();
      check(16'(cyc - t0), 16'(1 << (8 + c)));
    end
    wr(4'h0, 8'h00);
    rd(4'h1, 8'h07);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire

// >>> misw_timebase.sv
// Purpose: Second time-base divider on the prescaler-1 clock
// Assumes: prescaler clock arrives as a one-cycle enable from the same domain
// Notes:   Period is 2^(8+code) prescaler ticks
`timescale 1ns/1ps
`default_nettype none
module misw_timebase #(
  parameter int unsigned CW = 16
) (
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire logic       enable_i,
  input  wire logic       tick_i,
  input  wire logic [2:0] period_i,
  output logic            ovf_o
);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic [4:0]    exp_w;
  logic          hit_w;

  assign exp_w   = 5'(misw_pkg::TB_BASE_EXP) + {2'b00, period_i};
  assign hit_w   = (cnt_r == CW'((32'h0000_0001 << exp_w) - 32'h0000_0001));
  assign cnt_nxt = (!enable_i) ? '0 : (tick_i ? (hit_w ? '0 : cnt_r + 1'b1) : cnt_r);

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
      ovf_o <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      ovf_o <= enable_i & tick_i & hit_w;
    end
  end
endmodule : misw_timebase
`default_nettype wire
